/* File: hdbw_pkg.sv */
// Package: register indices, fields, codes and carrier types for the watch unit
package hdbw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (word index, byte address is four times the index)
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_EVDATA = 8'h16;
  localparam logic [7:0] IDX_HALT = 8'h18;
  localparam logic [7:0] IDX_SCR = 8'h20;
  localparam logic [7:0] IDX_IBA = 8'h30;
  localparam logic [7:0] IDX_IBC = 8'h40;
  localparam logic [7:0] IDX_DWA1 = 8'h50;
  localparam logic [7:0] IDX_DWA2 = 8'h60;
  localparam logic [7:0] IDX_DWC = 8'h70;
  localparam logic [7:0] IDX_RWM = 8'h80;
  localparam logic [7:0] IDX_RWV = 8'h90;
  localparam logic [7:0] IDX_RWC = 8'h9c;
  localparam logic [7:0] IDX_STAT = 8'ha0;
  localparam logic [7:0] IDX_IEN = 8'ha1;
  localparam logic [7:0] IDX_ICLR = 8'ha2;
  localparam logic [7:0] IDX_HOSTREQ = 8'ha3;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and writable-bit masks
  localparam int CTL_EN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_LOAD = 2;
  localparam int CTL_TM_LO = 16;
  localparam int CAUSE_THR_LO = 8;
  localparam int CAUSE_UNIT_LO = 16;
  localparam logic [31:0] IBC_WMASK = 32'h00ff0003;
  localparam logic [31:0] DWC_WMASK = 32'h00ff0007;
  localparam logic [31:0] RWC_WMASK = 32'h00ff0003;
  localparam logic [31:0] HALT_WMASK = 32'h000000ff;
  localparam logic [31:0] CAUSE_WMASK = 32'h0003ff07;

  ////////////////////////////////////////////////////////////////////////////
  // Cause codes and interrupt status bits
  localparam logic [2:0] CODE_HOST = 3'h1;
  localparam logic [2:0] CODE_DEBUG_CALL_INSTRUCTION = 3'h2;
  localparam logic [2:0] CODE_IBREAK = 3'h3;
  localparam logic [2:0] CODE_DWATCH = 3'h4;
  localparam logic [2:0] CODE_RWATCH = 3'h5;
  localparam int NEV = 5;
  localparam int EV_HOST = 0;
  localparam int EV_DEBUG_CALL_INSTRUCTION = 1;
  localparam int EV_IBREAK = 2;
  localparam int EV_DWATCH = 3;
  localparam int EV_RWATCH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef enum logic [1:0] {
    HDBW_IDLE = 2'b01,
    HDBW_ACK = 2'b10
  } hdbw_bus_t;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] pc;
  } hdbw_fetch_t;

  typedef struct packed {
    logic valid;
    logic load;
    logic [2:0] thread;
    logic [31:0] addr;
  } hdbw_mem_t;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] id;
  } hdbw_res_t;

  typedef struct packed {
    hdbw_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] cause;
    logic [31:0] evdata;
    logic [7:0] halt;
    logic [7:0][31:0] scr;
    logic [3:0][31:0] iba;
    logic [3:0][31:0] ibc;
    logic [3:0][31:0] dwa1;
    logic [3:0][31:0] dwa2;
    logic [3:0][31:0] dwc;
    logic [3:0][31:0] rwm;
    logic [3:0][31:0] rwv;
    logic [3:0][31:0] rwc;
    logic [NEV-1:0] stat;
    logic [NEV-1:0] ien;
    logic irq;
    logic dbg_req;
    logic [7:0] stop;
    logic [31:0] cfg_rdata;
  } hdbw_state_t;

endpackage : hdbw_pkg

/* File: hdbw_watch_unit.sv */
// Hardware breakpoint and watchpoint unit with Avalon-MM register slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module hdbw_watch_unit #(
  parameter int NUNITS = 4,
  parameter int NTHREADS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cfg_write,
  input wire logic [2:0] cfg_index,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire hdbw_pkg::hdbw_fetch_t fetch,
  input wire hdbw_pkg::hdbw_mem_t mem,
  input wire hdbw_pkg::hdbw_res_t res,
  input wire logic host_req,
  input wire logic debug_call_instruction,
  input wire logic [2:0] debug_call_instruction_thread,
  input wire logic debug_mode_read_write,
  output logic dbg_req,
  output logic [7:0] thread_stop,
  output logic irq
);

  if (NUNITS != 4 || NTHREADS != 8) begin : g_chk
    $error("hdbw_watch_unit supports four units and eight threads only");
  end

  hdbw_pkg::hdbw_state_t s_q;
  hdbw_pkg::hdbw_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Match logic
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;
  logic [1:0] ib_unit;
  logic [1:0] dw_unit;
  logic [1:0] rw_unit;
  logic [hdbw_pkg::NEV-1:0] ev;
  logic host_seen;

  always_comb begin
    logic ca;
    logic cb;
    logic rc;
    ib_hit = '0;
    dw_hit = '0;
    rw_hit = '0;
    ib_unit = '0;
    dw_unit = '0;
    rw_unit = '0;
    ca = 1'b0;
    cb = 1'b0;
    rc = 1'b0;
    for (int i = NUNITS - 1; i >= 0; i--) begin
      // Instruction breakpoints
      ib_hit[i] = fetch.valid
        && s_q.ibc[i][hdbw_pkg::CTL_EN]
        && s_q.ibc[i][hdbw_pkg::CTL_TM_LO + fetch.thread]
        && ((fetch.pc == s_q.iba[i])
        ^ s_q.ibc[i][hdbw_pkg::CTL_MODE]);
      // Data watchpoints: A is at or above first and at or below second, B is either one
      ca = mem.addr >= s_q.dwa1[i];
      cb = mem.addr <= s_q.dwa2[i];
      dw_hit[i] = mem.valid && s_q.dwc[i][hdbw_pkg::CTL_EN]
        && s_q.dwc[i][hdbw_pkg::CTL_TM_LO + mem.thread]
        && (!mem.load || s_q.dwc[i][hdbw_pkg::CTL_LOAD])
        && (s_q.dwc[i][hdbw_pkg::CTL_MODE]
        ? (ca || cb) : (ca && cb));
      // Resource watchpoints: A is masked equal, B is masked differ
      rc = (res.id & s_q.rwm[i]) == s_q.rwv[i];
      rw_hit[i] = res.valid && s_q.rwc[i][hdbw_pkg::CTL_EN]
        && s_q.rwc[i][hdbw_pkg::CTL_TM_LO + res.thread]
        && (s_q.rwc[i][hdbw_pkg::CTL_MODE] ? !rc : rc);
      // Descending loop leaves the lowest unit number
      if (ib_hit[i]) begin
        ib_unit = 2'(i);
      end
      if (dw_hit[i]) begin
        dw_unit = 2'(i);
      end
      if (rw_hit[i]) begin
        rw_unit = 2'(i);
      end
    end
  end

  // Host request may come from the input pin or a register write
  assign host_seen = host_req || (s_q.bus == hdbw_pkg::HDBW_ACK && avs_write
    && avs_address == hdbw_pkg::IDX_HOSTREQ && avs_writedata[0]);

  // Triggers are ignored while the core already runs the debug handler
  always_comb begin
    ev = '0;
    ev[hdbw_pkg::EV_HOST] = host_seen;
    ev[hdbw_pkg::EV_DEBUG_CALL_INSTRUCTION] = debug_call_instruction;
    ev[hdbw_pkg::EV_IBREAK] = |ib_hit;
    ev[hdbw_pkg::EV_DWATCH] = |dw_hit;
    ev[hdbw_pkg::EV_RWATCH] = |rw_hit;
    if (debug_mode_read_write) begin
      ev = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic acc;
    logic wr;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] bm;
    s_d = s_q;
    a = avs_address;
    bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    acc = avs_read || avs_write;
    wr = s_q.bus == hdbw_pkg::HDBW_ACK && avs_write;
    wd = '0;
    s_d.dbg_req = 1'b0;
    s_d.cfg_rdata = s_q.scr[cfg_index];
    if (cfg_write) begin
      s_d.scr[cfg_index] = cfg_wdata;
    end
    // Bus handshake: one wait cycle, then answer; writes commit at answer
    unique case (s_q.bus)
      hdbw_pkg::HDBW_IDLE: begin
        s_d.waitreq = 1'b1;
        if (acc) begin
          s_d.bus = hdbw_pkg::HDBW_ACK;
          s_d.waitreq = 1'b0;
          s_d.rdata = '0;
          if (avs_read) begin
            if (a == hdbw_pkg::IDX_CAUSE) begin
              s_d.rdata = s_q.cause;
            end else if (a == hdbw_pkg::IDX_EVDATA) begin
              s_d.rdata = s_q.evdata;
            end else if (a == hdbw_pkg::IDX_HALT) begin
              s_d.rdata = 32'(s_q.halt);
            end else if (a[7:3] == hdbw_pkg::IDX_SCR[7:3]) begin
              s_d.rdata = s_q.scr[a[2:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_IBA[7:2]) begin
              s_d.rdata = s_q.iba[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_IBC[7:2]) begin
              s_d.rdata = s_q.ibc[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_DWA1[7:2]) begin
              s_d.rdata = s_q.dwa1[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_DWA2[7:2]) begin
              s_d.rdata = s_q.dwa2[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_DWC[7:2]) begin
              s_d.rdata = s_q.dwc[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_RWM[7:2]) begin
              s_d.rdata = s_q.rwm[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_RWV[7:2]) begin
              s_d.rdata = s_q.rwv[a[1:0]];
            end else if (a[7:2] == hdbw_pkg::IDX_RWC[7:2]) begin
              s_d.rdata = s_q.rwc[a[1:0]];
            end else if (a == hdbw_pkg::IDX_STAT) begin
              s_d.rdata = 32'(s_q.stat);
            end else if (a == hdbw_pkg::IDX_IEN) begin
              s_d.rdata = 32'(s_q.ien);
            end
          end
        end
      end
      hdbw_pkg::HDBW_ACK: begin
        s_d.bus = hdbw_pkg::HDBW_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase
    // Register writes, byte lanes honoured except for IEN, ICLR and HOSTREQ
    if (wr) begin
      if (a == hdbw_pkg::IDX_CAUSE) begin
        wd = (s_q.cause & ~bm) | (avs_writedata & bm);
        s_d.cause = wd & hdbw_pkg::CAUSE_WMASK;
      end else if (a == hdbw_pkg::IDX_EVDATA) begin
        s_d.evdata = (s_q.evdata & ~bm) | (avs_writedata & bm);
      end else if (a == hdbw_pkg::IDX_HALT) begin
        wd = (avs_writedata & bm) | (32'(s_q.halt) & ~bm);
        s_d.halt = wd[7:0];
      end else if (a[7:3] == hdbw_pkg::IDX_SCR[7:3]) begin
        wd = (s_q.scr[a[2:0]] & ~bm) | (avs_writedata & bm);
        s_d.scr[a[2:0]] = wd;
      end else if (a[7:2] == hdbw_pkg::IDX_IBA[7:2]) begin
        s_d.iba[a[1:0]] = (s_q.iba[a[1:0]] & ~bm) | (avs_writedata & bm);
      end else if (a[7:2] == hdbw_pkg::IDX_IBC[7:2]) begin
        wd = (s_q.ibc[a[1:0]] & ~bm) | (avs_writedata & bm);
        s_d.ibc[a[1:0]] = wd & hdbw_pkg::IBC_WMASK;
      end else if (a[7:2] == hdbw_pkg::IDX_DWA1[7:2]) begin
        s_d.dwa1[a[1:0]] = (s_q.dwa1[a[1:0]] & ~bm) | (avs_writedata & bm);
      end else if (a[7:2] == hdbw_pkg::IDX_DWA2[7:2]) begin
        s_d.dwa2[a[1:0]] = (s_q.dwa2[a[1:0]] & ~bm) | (avs_writedata & bm);
      end else if (a[7:2] == hdbw_pkg::IDX_DWC[7:2]) begin
        wd = (s_q.dwc[a[1:0]] & ~bm) | (avs_writedata & bm);
        s_d.dwc[a[1:0]] = wd & hdbw_pkg::DWC_WMASK;
      end else if (a[7:2] == hdbw_pkg::IDX_RWM[7:2]) begin
        s_d.rwm[a[1:0]] = (s_q.rwm[a[1:0]] & ~bm) | (avs_writedata & bm);
      end else if (a[7:2] == hdbw_pkg::IDX_RWV[7:2]) begin
        s_d.rwv[a[1:0]] = (s_q.rwv[a[1:0]] & ~bm) | (avs_writedata & bm);
      end else if (a[7:2] == hdbw_pkg::IDX_RWC[7:2]) begin
        wd = (s_q.rwc[a[1:0]] & ~bm) | (avs_writedata & bm);
        s_d.rwc[a[1:0]] = wd & hdbw_pkg::RWC_WMASK;
      end else if (a == hdbw_pkg::IDX_IEN) begin
        s_d.ien = avs_writedata[hdbw_pkg::NEV-1:0];
      end else if (a == hdbw_pkg::IDX_ICLR) begin
        s_d.stat = s_q.stat & ~avs_writedata[hdbw_pkg::NEV-1:0];
      end
    end
    // Event capture, host first then ascending cause code
    if (|ev) begin
      s_d.dbg_req = 1'b1;
      s_d.cause = '0;
      if (ev[hdbw_pkg::EV_HOST]) begin
        s_d.cause[2:0] = hdbw_pkg::CODE_HOST;
      end else if (ev[hdbw_pkg::EV_DEBUG_CALL_INSTRUCTION]) begin
        s_d.cause[2:0] = hdbw_pkg::CODE_DEBUG_CALL_INSTRUCTION;
        s_d.cause[hdbw_pkg::CAUSE_THR_LO +: 3] = debug_call_instruction_thread;
      end else if (ev[hdbw_pkg::EV_IBREAK]) begin
        s_d.cause[2:0] = hdbw_pkg::CODE_IBREAK;
        s_d.cause[hdbw_pkg::CAUSE_UNIT_LO +: 2] = ib_unit;
        s_d.cause[hdbw_pkg::CAUSE_THR_LO +: 3] = fetch.thread;
      end else if (ev[hdbw_pkg::EV_DWATCH]) begin
        s_d.cause[2:0] = hdbw_pkg::CODE_DWATCH;
        s_d.cause[hdbw_pkg::CAUSE_UNIT_LO +: 2] = dw_unit;
        s_d.cause[hdbw_pkg::CAUSE_THR_LO +: 3] = mem.thread;
        s_d.evdata = mem.addr;
      end else begin
        s_d.cause[2:0] = hdbw_pkg::CODE_RWATCH;
        s_d.cause[hdbw_pkg::CAUSE_UNIT_LO +: 2] = rw_unit;
        s_d.cause[hdbw_pkg::CAUSE_THR_LO +: 3] = res.thread;
        s_d.evdata = res.id;
      end
    end
    // Set wins over a clear in the same cycle
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_d.ien);
    // Halt mask applies whenever debug mode is left, so steps stay gated
    s_d.stop = debug_mode_read_write ? '0 : s_d.halt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.bus <= hdbw_pkg::HDBW_IDLE;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign cfg_rdata = s_q.cfg_rdata;
  assign dbg_req = s_q.dbg_req;
  assign thread_stop = s_q.stop;
  assign irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (rst);

  dw_evdata_a: assert property (
    !debug_mode_read_write && !host_seen && !debug_call_instruction && ib_hit == '0
    && dw_hit != '0 |=> s_q.evdata == $past(mem.addr)
  ) else $error("data watch address not captured");

  rw_evdata_a: assert property (
    !debug_mode_read_write && !host_seen && !debug_call_instruction && ib_hit == '0
    && dw_hit == '0 && rw_hit != '0 |=> s_q.evdata == $past(res.id)
  ) else $error("resource id not captured");

  halt_stop_a: assert property (
    !debug_mode_read_write |=> thread_stop == s_q.halt
  ) else $error("halted thread not stopped");

  dbg_free_a: assert property (
    debug_mode_read_write |=> thread_stop == '0
  ) else $error("thread stopped while in debug mode");

  scr_share_a: assert property (
    !cfg_write && !avs_write ##1 !cfg_write && !avs_write
    |=> cfg_rdata == s_q.scr[$past(cfg_index)]
  ) else $error("scratch view mismatch");

  ib_req_a: assert property (
    fetch.valid && !debug_mode_read_write && ib_hit != '0 |=> dbg_req
  ) else $error("breakpoint hit gave no request");

  ib_disabled_a: assert property (
    !s_q.ibc[0][hdbw_pkg::CTL_EN] |-> !ib_hit[0]
  ) else $error("disabled breakpoint fired");

  tmask_gate_a: assert property (
    fetch.valid && !s_q.ibc[1][hdbw_pkg::CTL_TM_LO + fetch.thread]
    |-> !ib_hit[1]
  ) else $error("thread mask ignored");

  load_gate_a: assert property (
    mem.valid && mem.load && !s_q.dwc[2][hdbw_pkg::CTL_LOAD] |-> !dw_hit[2]
  ) else $error("load triggered without load enable");

  unit_low_a: assert property (
    !debug_mode_read_write && !host_seen && !debug_call_instruction
    && ib_hit[2:1] == 2'b11 && !ib_hit[0]
    |=> s_q.cause[hdbw_pkg::CAUSE_UNIT_LO +: 2] == 2'h1
    && s_q.cause[2:0] == hdbw_pkg::CODE_IBREAK
  ) else $error("lowest breakpoint not reported");

  wait_once_a: assert property (
    !avs_waitrequest |=> avs_waitrequest
  ) else $error("waitrequest low for two cycles");

  ib_equal_a: assert property (
    fetch.valid && !s_q.ibc[0][hdbw_pkg::CTL_MODE] && fetch.pc != s_q.iba[0]
    |-> !ib_hit[0]
  ) else $error("breakpoint fired on unequal address");

  dw_and_a: assert property (
    mem.valid && !s_q.dwc[0][hdbw_pkg::CTL_MODE] && mem.addr > s_q.dwa2[0]
    |-> !dw_hit[0]
  ) else $error("data watch ignored the and mode");

  rw_mask_a: assert property (
    res.valid && !s_q.rwc[0][hdbw_pkg::CTL_MODE]
    && (res.id & s_q.rwm[0]) != s_q.rwv[0] |-> !rw_hit[0]
  ) else $error("resource watch fired on masked mismatch");

  dbg_quiet_a: assert property (
    debug_mode_read_write |=> !dbg_req
  ) else $error("debug request while in debug mode");

  stat_sticky_a: assert property (
    !(avs_write && avs_address == hdbw_pkg::IDX_ICLR)
    |=> (s_q.stat & $past(s_q.stat)) == $past(s_q.stat)
  ) else $error("status bit lost without a clear");

  dw_cause_a: assert property (
    !debug_mode_read_write && !host_seen && !debug_call_instruction && ib_hit == '0
    && dw_hit != '0 |=> s_q.cause[2:0] == hdbw_pkg::CODE_DWATCH
  ) else $error("data watch cause not recorded");

  c_ib_hit_c: cover property (fetch.valid && ib_hit != '0 ##1 dbg_req);
  c_dw_hit_c: cover property (mem.valid && dw_hit != '0 ##1 dbg_req);
  c_rw_irq_c: cover property (rw_hit != '0 ##2 irq);
  c_host_c: cover property (host_seen && !debug_mode_read_write ##1 dbg_req);
  c_step_c: cover property (debug_mode_read_write ##1 !debug_mode_read_write
    ##1 thread_stop != '0);

endmodule : hdbw_watch_unit

/* File: hdbw_core_model.sv */
// Core pipeline model: issues fetch, memory, resource and debug traffic
`timescale 1ns/1ps
module hdbw_core_model (
  input wire logic clk,
  output hdbw_pkg::hdbw_fetch_t fetch,
  output hdbw_pkg::hdbw_mem_t mem,
  output hdbw_pkg::hdbw_res_t res,
  output logic host_req,
  output logic debug_call_instruction,
  output logic [2:0] debug_call_instruction_thread,
  output logic debug_mode_read_write
);
  initial begin
    fetch = '0;
    mem = '0;
    res = '0;
    host_req = 1'b0;
    debug_call_instruction = 1'b0;
    debug_call_instruction_thread = 3'h0;
    debug_mode_read_write = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle operation; idle payloads flip so stale values never match
  task automatic issue(input int kind, input logic ld, input logic [2:0] thr,
      input logic [31:0] v);
    @(posedge clk);
    case (kind)
      0: fetch <= '{1'b1, thr, v};
      1: mem <= '{1'b1, ld, thr, v};
      2: res <= '{1'b1, thr, v};
      4: host_req <= 1'b1;
      default: begin
        debug_call_instruction <= 1'b1;
        debug_call_instruction_thread <= thr;
      end
    endcase
    @(posedge clk);
    fetch <= '{1'b0, ~fetch.thread, ~fetch.pc};
    mem <= '{1'b0, ~mem.load, ~mem.thread, ~mem.addr};
    res <= '{1'b0, ~res.thread, ~res.id};
    debug_call_instruction <= 1'b0;
    host_req <= 1'b0;
    debug_call_instruction_thread <= ~debug_call_instruction_thread;
  endtask : issue

  task automatic set_debug(input logic m);
    @(posedge clk);
    debug_mode_read_write <= m;
  endtask : set_debug
endmodule : hdbw_core_model

/* File: test_hdbw_watch_unit.sv */
// Self-checking bench for the breakpoint and watchpoint unit
`timescale 1ns/1ps
module test_hdbw_watch_unit;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, cfg_write;
  logic host_req, debug_call_instruction, debug_mode_read_write, dbg_req, irq;
  logic [7:0] avs_address, thread_stop;
  logic [31:0] avs_writedata, avs_readdata, cfg_wdata, cfg_rdata;
  logic [3:0] avs_byteenable;
  logic [2:0] cfg_index, debug_call_instruction_thread;
  hdbw_pkg::hdbw_fetch_t fetch;
  hdbw_pkg::hdbw_mem_t mem;
  hdbw_pkg::hdbw_res_t res;
  int errors = 0;
  int num_checks = 0;

  hdbw_watch_unit dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .fetch(fetch), .mem(mem), .res(res),
    .host_req(host_req), .debug_call_instruction(debug_call_instruction), .debug_call_instruction_thread(debug_call_instruction_thread),
    .debug_mode_read_write(debug_mode_read_write), .dbg_req(dbg_req),
    .thread_stop(thread_stop), .irq(irq));

  hdbw_core_model core (.clk(clk), .fetch(fetch), .mem(mem), .res(res),
    .host_req(host_req), .debug_call_instruction(debug_call_instruction), .debug_call_instruction_thread(debug_call_instruction_thread),
    .debug_mode_read_write(debug_mode_read_write));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Avalon master: hold request until waitrequest sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask : rdc

  // Core operation, then look at the one-cycle debug request pulse
  task automatic ev(input int k, input logic ld, input logic [2:0] t,
      input logic [31:0] v, input logic e);
    core.issue(k, ld, t, v);
    @(posedge clk);
    chk({31'h0, dbg_req}, {31'h0, e});
  endtask : ev

  function automatic logic [31:0] cz(input logic [2:0] c, input logic [1:0] u,
      input logic [2:0] t);
    return {14'h0, u, 5'h0, t, 5'h0, c};
  endfunction : cz

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    cfg_write = 1'b0;
    cfg_index = 3'h0;
    cfg_wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(hdbw_pkg::IDX_IBC, 32'h0);
    rdc(hdbw_pkg::IDX_DWC + 8'h1, 32'h0);
    rdc(hdbw_pkg::IDX_RWC + 8'h3, 32'h0);
    wr(hdbw_pkg::IDX_IBC, 32'hffffffff);
    rdc(hdbw_pkg::IDX_IBC, hdbw_pkg::IBC_WMASK);
    wr(hdbw_pkg::IDX_DWC + 8'h1, 32'hffffffff);
    rdc(hdbw_pkg::IDX_DWC + 8'h1, hdbw_pkg::DWC_WMASK);
    wr(hdbw_pkg::IDX_RWC + 8'h3, 32'hffffffff);
    rdc(hdbw_pkg::IDX_RWC + 8'h3, hdbw_pkg::RWC_WMASK);
    wr(hdbw_pkg::IDX_IBC, 32'h0);
    wr(hdbw_pkg::IDX_DWC + 8'h1, 32'h0);
    wr(hdbw_pkg::IDX_RWC + 8'h3, 32'h0);
    wr(hdbw_pkg::IDX_IBA + 8'h3, 32'h12345670);
    rdc(hdbw_pkg::IDX_IBA + 8'h3, 32'h12345670);
    wr(hdbw_pkg::IDX_DWA2 + 8'h2, 32'hfedc0004);
    rdc(hdbw_pkg::IDX_DWA2 + 8'h2, 32'hfedc0004);
    wr(hdbw_pkg::IDX_RWM + 8'h1, 32'h0f0f1111);
    rdc(hdbw_pkg::IDX_RWM + 8'h1, 32'h0f0f1111);
    wr(hdbw_pkg::IDX_RWV + 8'h2, 32'h2222f0f0);
    rdc(hdbw_pkg::IDX_RWV + 8'h2, 32'h2222f0f0);
    wr(8'h01, 32'hdeadbeef);
    rdc(8'h01, 32'h0);
    $display("test registers done");
    // Scratch words through both access paths
    for (int i = 0; i < 8; i++) begin
      wr(hdbw_pkg::IDX_SCR + 8'(i), 32'ha5a50000 + i);
    end
    rdc(hdbw_pkg::IDX_SCR + 8'h7, 32'ha5a50007);
    cfg_index <= 3'h6;
    repeat (2) @(posedge clk);
    chk(cfg_rdata, 32'ha5a50006);
    cfg_write <= 1'b1;
    cfg_index <= 3'h2;
    cfg_wdata <= 32'hc0de0002;
    @(posedge clk);
    cfg_write <= 1'b0;
    rdc(hdbw_pkg::IDX_SCR + 8'h2, 32'hc0de0002);
    $display("test scratch done");
    // Halt mask versus debug mode
    wr(hdbw_pkg::IDX_HALT, 32'hffffffa5);
    rdc(hdbw_pkg::IDX_HALT, 32'h000000a5);
    chk({24'h0, thread_stop}, 32'ha5);
    core.set_debug(1'b1);
    repeat (2) @(posedge clk);
    chk({24'h0, thread_stop}, 32'h0);
    ev(3, 1'b0, 3'h0, 32'h0, 1'b0);
    core.set_debug(1'b0);
    repeat (2) @(posedge clk);
    chk({24'h0, thread_stop}, 32'ha5);
    $display("test halt done");
    // Instruction breakpoints: thread mask, enable, mode, priority
    wr(hdbw_pkg::IDX_IEN, 32'h1f);
    wr(hdbw_pkg::IDX_IBA + 8'h1, 32'h400);
    wr(hdbw_pkg::IDX_IBA + 8'h2, 32'h400);
    wr(hdbw_pkg::IDX_IBC + 8'h2, 32'h00080001);
    ev(0, 1'b0, 3'h3, 32'h400, 1'b1);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h3, 2'h2, 3'h3));
    wr(hdbw_pkg::IDX_IBC + 8'h1, 32'h00080001);
    ev(0, 1'b0, 3'h3, 32'h400, 1'b1);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h3, 2'h1, 3'h3));
    ev(0, 1'b0, 3'h4, 32'h400, 1'b0);
    wr(hdbw_pkg::IDX_IBC + 8'h1, 32'h0);
    wr(hdbw_pkg::IDX_IBC + 8'h2, 32'h00080000);
    ev(0, 1'b0, 3'h3, 32'h400, 1'b0);
    wr(hdbw_pkg::IDX_IBC + 8'h2, 32'h00080003);
    ev(0, 1'b0, 3'h3, 32'h400, 1'b0);
    ev(0, 1'b0, 3'h3, 32'h404, 1'b1);
    wr(hdbw_pkg::IDX_IBC + 8'h2, 32'h0);
    $display("test breakpoints done");
    // Data watchpoint 0: window 0x100..0x1ff, AND then OR, loads gated
    wr(hdbw_pkg::IDX_DWA1, 32'h100);
    wr(hdbw_pkg::IDX_DWA2, 32'h1ff);
    wr(hdbw_pkg::IDX_DWC, 32'h00010001);
    ev(1, 1'b0, 3'h0, 32'h180, 1'b1);
    rdc(hdbw_pkg::IDX_EVDATA, 32'h180);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h4, 2'h0, 3'h0));
    ev(1, 1'b1, 3'h0, 32'h180, 1'b0);
    ev(1, 1'b0, 3'h0, 32'h300, 1'b0);
    wr(hdbw_pkg::IDX_DWC, 32'h00010007);
    ev(1, 1'b1, 3'h0, 32'h300, 1'b1);
    rdc(hdbw_pkg::IDX_EVDATA, 32'h300);
    wr(hdbw_pkg::IDX_DWC, 32'h0);
    // Resource watchpoint 0: masked identifier compare, A then B
    wr(hdbw_pkg::IDX_RWM, 32'hff00);
    wr(hdbw_pkg::IDX_RWV, 32'h1200);
    wr(hdbw_pkg::IDX_RWC, 32'h00400001);
    ev(2, 1'b0, 3'h6, 32'h1234, 1'b1);
    rdc(hdbw_pkg::IDX_EVDATA, 32'h1234);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h5, 2'h0, 3'h6));
    ev(2, 1'b0, 3'h6, 32'h1334, 1'b0);
    wr(hdbw_pkg::IDX_RWC, 32'h00400003);
    ev(2, 1'b0, 3'h6, 32'h1334, 1'b1);
    wr(hdbw_pkg::IDX_RWC, 32'h0);
    $display("test watchpoints done");
    // Host and call causes, then interrupt status, mask and clear
    wr(hdbw_pkg::IDX_HOSTREQ, 32'h1);
    repeat (2) @(posedge clk);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h1, 2'h0, 3'h0));
    ev(3, 1'b0, 3'h5, 32'h0, 1'b1);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h2, 2'h0, 3'h5));
    ev(4, 1'b0, 3'h0, 32'h0, 1'b1);
    rdc(hdbw_pkg::IDX_CAUSE, cz(3'h1, 2'h0, 3'h0));
    rdc(hdbw_pkg::IDX_STAT, 32'h1f);
    chk({31'h0, irq}, 32'h1);
    wr(hdbw_pkg::IDX_IEN, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(hdbw_pkg::IDX_ICLR, 32'h1f);
    rdc(hdbw_pkg::IDX_STAT, 32'h0);
    $display("test interrupts done");
    give_verdict();
  end
endmodule : test_hdbw_watch_unit
